/* design/frtm_unit.sv */
// rounding, range check and trap mode logic of the floating-point operate path
`timescale 1ns/1ps
`default_nettype none
module frtm_unit #(
  parameter int FRAC_W = 52 // fraction width; only 52 is served
) (
  input wire logic clock_in, // 40 mhz core clock
  input wire logic nrst_in, // synchronous, active low
  input wire logic op_valid_in, // one operation this cycle
  input wire frtm_pkg::frtm_op_t op_in, // true result and modifiers
  input wire logic barrier_in, // barrier or privileged call at issue
  input wire logic trap_ack_in, // dispatch has taken the trap
  output logic res_valid_out, // result valid, one cycle
  output frtm_pkg::frtm_res_t res_out, // rounded result and flags
  output logic trap_req_out, // an arithmetic trap is pending
  output frtm_pkg::frtm_exc_t trap_exc_out, // flags of pending trap
  output logic trap_sw_out, // software completion copy
  output logic barrier_hold_out, // barrier must wait
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr // apb error on unmapped
);
  import frtm_pkg::*;
  // one operation per cycle, no back-pressure
  // result and flags leave one cycle later
  // pending traps wait for the dispatch ack
  // barrier holds while anything may trap

  // --------------------------------------------------------------
  // elaboration check
  // --------------------------------------------------------------
  // incrementer and encoder are sized for 52 bits
  if (FRAC_W != FRTM_FRAC_W) begin : g_bad_width
    $error("frtm_unit serves a 52 bit fraction only");
  end

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  // every flop below resets synchronously
  // the control word splits across two apb words
  logic [1:0] dyn_ff; // dynamic rounding field
  frtm_exc_t fpc_exc_ff; // sticky control exception bits
  logic res_valid_ff; // output stage valid
  frtm_res_t res_ff; // output stage data
  logic pend_ff; // trap pending
  frtm_exc_t pend_exc_ff; // accumulated trap flags
  logic pend_sw_ff; // accumulated software bit

  // --------------------------------------------------------------
  // rounding direction decode
  // --------------------------------------------------------------
  // legacy ignores the dynamic field entirely
  // decode is pure logic, no extra stage
  frtm_dir_t dir; // direction used for this operation
  logic [1:0] eff_rnd; // rnd after dynamic substitution
  always_comb begin
    // dynamic code pulls the direction from the control field
    eff_rnd = (op_in.rnd == FRTM_RND_DYN) ? dyn_ff : op_in.rnd;
    dir = FRTM_DIR_NEAR_EVEN;
    if (!op_in.is_std) begin
      // legacy has only normal and chopped; other codes read as normal
      dir = (op_in.rnd == FRTM_RND_CHOP) ? FRTM_DIR_ZERO : FRTM_DIR_NEAR_AWAY;
    end else begin
      case (eff_rnd)
        FRTM_RND_CHOP: dir = FRTM_DIR_ZERO;
        FRTM_RND_MINUS: dir = FRTM_DIR_MINUS;
        FRTM_RND_NORM: dir = FRTM_DIR_NEAR_EVEN;
        // plus only arises through the dynamic field
        FRTM_RND_DYN: dir = FRTM_DIR_PLUS;
        default: dir = FRTM_DIR_NEAR_EVEN;
      endcase
    end
  end

  // --------------------------------------------------------------
  // rounding increment and mantissa add
  // --------------------------------------------------------------
  // one incrementer serves all five directions
  // a carry renormalises to 1.0 at exp plus one
  // directed rounding looks only at the sign and the lost bits
  logic inc; // add one lsb
  logic lost; // bits below lsb were non-zero
  logic [53:0] mant_sum; // hidden bit, fraction, carry
  logic signed [13:0] r_exp; // exponent after rounding
  logic [51:0] r_frac; // fraction after rounding
  always_comb begin
    lost = op_in.rbit | op_in.sticky;
    // an exact result never gets an increment under any direction
    case (dir)
      FRTM_DIR_NEAR_EVEN: inc = op_in.rbit & (op_in.sticky | op_in.frac[0]);
      FRTM_DIR_NEAR_AWAY: inc = op_in.rbit;
      FRTM_DIR_ZERO: inc = 1'b0;
      FRTM_DIR_PLUS: inc = lost & !op_in.sign;
      FRTM_DIR_MINUS: inc = lost & op_in.sign;
      default: inc = 1'b0;
    endcase
    mant_sum = {2'b01, op_in.frac} + {53'h0, inc};
    // a carry out of the mantissa steps the exponent up
    r_exp = op_in.exp + (mant_sum[53] ? 14'sd1 : 14'sd0);
    r_frac = mant_sum[53] ? 52'h0 : mant_sum[51:0];
  end

  // --------------------------------------------------------------
  // range check on the rounded value
  // --------------------------------------------------------------
  // limits hold the 1.f form of each format
  // zero inputs never raise a range flag
  // the biased exponent is cut to eleven bits
  logic signed [13:0] emax; // largest exponent of the format
  logic signed [13:0] emin; // smallest normal exponent
  logic signed [13:0] bias; // encoding bias
  logic ovf; // rounded magnitude above max
  logic unf; // rounded non-zero magnitude below min
  logic [13:0] b_exp; // biased exponent
  always_comb begin
    emax = op_in.is_std ? FRTM_STD_EMAX : FRTM_LEG_EMAX;
    emin = op_in.is_std ? FRTM_STD_EMIN : FRTM_LEG_EMIN;
    bias = op_in.is_std ? FRTM_STD_BIAS : FRTM_LEG_BIAS;
    // checking after rounding gives each documented threshold exactly,
    // e.g. nearest overflows at max plus half an lsb
    ovf = !op_in.zero & (r_exp > emax);
    unf = !op_in.zero & (r_exp < emin);
    b_exp = 14'(r_exp + bias);
  end

  // --------------------------------------------------------------
  // exception flags and trap enables
  // --------------------------------------------------------------
  // flags are detected whatever the trap mode;
  // enables only gate the trap request
  // invalid and divide hide the derived flags
  frtm_exc_t exc; // conditions detected
  frtm_exc_t ena; // conditions allowed to trap
  logic trap; // this operation traps
  always_comb begin
    exc.inv = op_in.inv;
    exc.dze = op_in.dze & !op_in.inv;
    exc.ovf = ovf & !op_in.inv & !op_in.dze;
    exc.unf = unf & !op_in.inv & !op_in.dze;
    exc.ine = lost & !op_in.zero & !op_in.inv & !op_in.dze;
    exc.iov = op_in.iov & op_in.is_cvt;
    // invalid, divide and overflow always trap
    ena.inv = 1'b1;
    ena.dze = 1'b1;
    ena.ovf = 1'b1;
    // underflow enable from the u modifier on non-converts
    ena.unf = !op_in.is_cvt & op_in.tmod.enable;
    // int overflow enable from the v modifier on converts
    ena.iov = op_in.is_cvt & op_in.tmod.enable;
    // inexact only for standard ops with the i modifier
    ena.ine = op_in.is_std & op_in.tmod.inexact;
    // a disabled condition is masked alone
    trap = |(exc & ena);
  end

  // --------------------------------------------------------------
  // result value
  // --------------------------------------------------------------
  // underflow beats sign: no minus zero escapes an underflow
  logic [63:0] value; // encoded result
  always_comb begin
    if (unf || (op_in.zero && !op_in.is_std)) begin
      // underflow writes 64 zero bits whatever the sign or enable
      value = 64'h0;
    end else if (op_in.zero) begin
      value = {op_in.sign, 63'h0}; // standard keeps minus zero
    end else begin
      // on overflow the value is unpredictable; the raw field is kept
      value = {op_in.sign, b_exp[10:0], r_frac};
    end
  end

  // --------------------------------------------------------------
  // output stage
  // --------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      res_valid_ff <= 1'b0;
      res_ff <= '0;
    end else begin
      res_valid_ff <= op_valid_in;
      if (op_valid_in) begin
        res_ff.value <= value;
        res_ff.exc <= exc;
        res_ff.trap <= trap;
        // software bit never steers execution, only reporting
        res_ff.sw <= op_in.tmod.sw;
      end
    end
  end
  assign res_valid_out = res_valid_ff;
  assign res_out = res_ff;
  // data holds until the next valid operation,
  // so the far side may sample it late

  // --------------------------------------------------------------
  // pending trap accumulation
  // --------------------------------------------------------------
  // flags of traps in one shadow merge, so the
  // handler sees every condition at once
  // a trap in the ack cycle stays pending
  logic new_trap; // a trapping result leaves the output stage
  assign new_trap = res_valid_ff & res_ff.trap;
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      pend_ff <= 1'b0;
      pend_exc_ff <= '0;
      pend_sw_ff <= 1'b0;
    end else if (new_trap) begin
      // a trap during ack replaces the acked flags instead of merging: set wins
      pend_ff <= 1'b1;
      pend_exc_ff <= (trap_ack_in ? '0 : pend_exc_ff) | res_ff.exc;
      pend_sw_ff <= (trap_ack_in ? 1'b0 : pend_sw_ff) | res_ff.sw;
    end else if (trap_ack_in) begin
      pend_ff <= 1'b0;
      pend_exc_ff <= '0;
      pend_sw_ff <= 1'b0;
    end
  end
  // summary outputs come straight from flops
  assign trap_req_out = pend_ff;
  assign trap_exc_out = pend_exc_ff;
  assign trap_sw_out = pend_sw_ff;
  // a barrier waits for anything in flight and anything pending
  assign barrier_hold_out = barrier_in & (pend_ff | new_trap | res_valid_ff);

  // --------------------------------------------------------------
  // apb slave: zero wait states, error on unmapped
  // --------------------------------------------------------------
  // same clock as the core, so no synchroniser;
  // control low word is reserved and reads zero
  logic acc; // access phase
  logic wr_hi; // write to control high word
  logic hit; // mapped address
  assign acc = psel & penable;
  assign hit = (paddr == FRTM_CTL_LO_ADDR) | (paddr == FRTM_CTL_HI_ADDR)
             | (paddr == FRTM_TRAP_ADDR);
  assign wr_hi = acc & pwrite & (paddr == FRTM_CTL_HI_ADDR);
  assign pready = 1'b1;
  assign pslverr = acc & !hit;

  // a write takes effect at the access edge
  // dynamic field, written by software
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      dyn_ff <= FRTM_DYN_RST;
    end else if (wr_hi) begin
      dyn_ff <= pwdata[FRTM_DYN_POS +: 2];
    end
  end

  // legacy ops leave the sticky bits alone
  // sticky exception bits: standard ops set, software writes clear
  frtm_exc_t fpc_set; // bits raised this cycle
  assign fpc_set = (op_valid_in && op_in.is_std) ? exc : '0;
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      fpc_exc_ff <= '0;
    end else if (wr_hi) begin
      // a set in the same cycle as the write survives
      fpc_exc_ff <= pwdata[FRTM_EXC_POS +: 6] | fpc_set;
    end else begin
      fpc_exc_ff <= fpc_exc_ff | fpc_set;
    end
  end

  // read data is valid only in the access phase
  // read mux; reserved bits read zero
  always_comb begin
    prdata = 32'h0;
    if (acc && !pwrite) begin
      case (paddr)
        FRTM_CTL_HI_ADDR: begin
          prdata[FRTM_SUM_POS] = |fpc_exc_ff;
          prdata[FRTM_DYN_POS +: 2] = dyn_ff;
          prdata[FRTM_EXC_POS +: 6] = fpc_exc_ff;
        end
        FRTM_TRAP_ADDR: begin
          prdata[5:0] = pend_exc_ff;
          prdata[FRTM_TRAP_SW_POS] = pend_sw_ff;
          prdata[FRTM_TRAP_PEND_POS] = pend_ff;
        end
        default: prdata = 32'h0;
      endcase
    end
  end

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  // result checks look at outputs a cycle after the op; direction and barrier checks look in the same cycle

  a_exact_pass: assert property (
    op_valid_in && !op_in.rbit && !op_in.sticky && !op_in.zero && !unf
    |=> res_out.value[51:0] == $past(op_in.frac))
    else $error("exact result was altered");
  a_unf_zero: assert property (
    op_valid_in && exc.unf |=> res_out.value == 64'h0 && res_out.exc.unf)
    else $error("underflow did not give true zero");
  a_dyn_plus: assert property (
    op_valid_in && op_in.is_std && op_in.rnd == FRTM_RND_DYN
    && dyn_ff == FRTM_RND_DYN |-> dir == FRTM_DIR_PLUS)
    else $error("dynamic 11 did not select plus");
  a_plus_static: assert property (
    op_valid_in && op_in.rnd != FRTM_RND_DYN |-> dir != FRTM_DIR_PLUS)
    else $error("plus reached without dynamic mode");
  a_inv_traps: assert property (
    op_valid_in && op_in.inv |=> res_out.trap ##1 trap_req_out)
    else $error("invalid operation did not trap");
  a_unf_masked: assert property (
    op_valid_in && !op_in.is_cvt && !op_in.tmod.enable && exc.unf
    && !exc.inv && !exc.ovf && !exc.ine |=> !res_out.trap)
    else $error("disabled underflow trapped");
  a_barrier_hold: assert property (
    barrier_in && trap_req_out |-> barrier_hold_out)
    else $error("barrier passed a pending trap");
  a_pend_keep: assert property (
    trap_req_out && !trap_ack_in |=> trap_req_out
    && ((trap_exc_out & $past(trap_exc_out)) == $past(trap_exc_out)))
    else $error("pending trap flags were lost");
  a_fpc_sticky: assert property (
    op_valid_in && op_in.is_std && exc.ovf |=> fpc_exc_ff.ovf)
    else $error("control overflow bit not set");
  // the pipeline answers every operation
  a_valid_pulse: assert property (
    op_valid_in |=> res_valid_out)
    else $error("result valid missing");
  // standard ties land on an even fraction
  a_tie_even: assert property (
    op_valid_in && op_in.is_std && dir == FRTM_DIR_NEAR_EVEN && op_in.rbit
    && !op_in.sticky && !op_in.zero && !unf |=> !res_out.value[0])
    else $error("standard tie not even");
  // legacy ties step away from zero
  a_tie_away: assert property (
    op_valid_in && dir == FRTM_DIR_NEAR_AWAY && op_in.rbit && !op_in.zero && !unf
    |=> res_out.value[51:0] == $past(op_in.frac) + 52'h1)
    else $error("legacy tie not away");
  // chopping never changes the fraction
  a_chop_keep: assert property (
    op_valid_in && dir == FRTM_DIR_ZERO && !op_in.zero && !unf
    |=> res_out.value[51:0] == $past(op_in.frac))
    else $error("chopped result was rounded");
  // overflow can never be masked
  a_ovf_traps: assert property (
    op_valid_in && exc.ovf |=> res_out.trap)
    else $error("overflow did not trap");
  // software bit is copied and nothing more
  a_sw_copy: assert property (
    op_valid_in |=> res_out.sw == $past(op_in.tmod.sw))
    else $error("software bit not copied");
  // an ack with no new trap empties the summary
  a_ack_clear: assert property (
    trap_ack_in && !new_trap |=> !trap_req_out && trap_exc_out == '0)
    else $error("ack did not clear pending trap");

  // main scenarios worth seeing in a run
  c_plus_round: cover property (op_valid_in && dir == FRTM_DIR_PLUS && inc);
  c_trap_taken: cover property (trap_req_out ##1 trap_ack_in);
  c_barrier_wait: cover property (barrier_hold_out [*2]);
  c_carry_out: cover property (op_valid_in && mant_sum[53]);
  c_ack_merge: cover property (new_trap && trap_ack_in);
endmodule : frtm_unit
`default_nettype wire

/* common/frtm_pkg.sv */
// package: constants, types and field layouts of the fp rounding and trap mode unit
package frtm_pkg;
  // --------------------------------------------------------------
  // register map over apb (byte addresses)
  // --------------------------------------------------------------
  localparam logic [11:0] FRTM_CTL_LO_ADDR = 12'h000; // control bits 31:0
  localparam logic [11:0] FRTM_CTL_HI_ADDR = 12'h004; // control bits 63:32
  localparam logic [11:0] FRTM_TRAP_ADDR = 12'h008; // pending trap summary
  // fields inside the high control word
  localparam int FRTM_SUM_POS = 31; // control bit 63
  localparam int FRTM_DYN_POS = 26; // control bits 59:58
  localparam int FRTM_EXC_POS = 20; // control bits 57:52
  // fields inside the trap summary word
  localparam int FRTM_TRAP_SW_POS = 6; // software completion copy
  localparam int FRTM_TRAP_PEND_POS = 7; // trap pending
  // --------------------------------------------------------------
  // reset values and number formats
  // --------------------------------------------------------------
  localparam logic [1:0] FRTM_DYN_RST = 2'h2; // nearest after reset
  localparam int FRTM_FRAC_W = 52; // fraction width of the double formats
  localparam int FRTM_EXP_W = 14; // signed unbiased exponent width
  localparam logic signed [13:0] FRTM_STD_EMAX = 14'sd1023;
  localparam logic signed [13:0] FRTM_STD_EMIN = -14'sd1022;
  localparam logic signed [13:0] FRTM_STD_BIAS = 14'sd1023;
  localparam logic signed [13:0] FRTM_LEG_EMAX = 14'sd1022;
  localparam logic signed [13:0] FRTM_LEG_EMIN = -14'sd1024;
  localparam logic signed [13:0] FRTM_LEG_BIAS = 14'sd1025;
  // rounding field codes, same in the instruction and the dynamic field
  localparam logic [1:0] FRTM_RND_CHOP = 2'h0;
  localparam logic [1:0] FRTM_RND_MINUS = 2'h1;
  localparam logic [1:0] FRTM_RND_NORM = 2'h2;
  localparam logic [1:0] FRTM_RND_DYN = 2'h3; // plus when in the field
  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    FRTM_DIR_NEAR_EVEN, FRTM_DIR_NEAR_AWAY, FRTM_DIR_ZERO,
    FRTM_DIR_PLUS, FRTM_DIR_MINUS
  } frtm_dir_t;
  // exception flags, ordered as control bits 57:52
  typedef struct packed {
    logic iov; logic ine; logic unf; logic ovf; logic dze; logic inv;
  } frtm_exc_t;
  // trap modifier bits of the instruction
  typedef struct packed {
    logic inexact; logic sw; logic enable;
  } frtm_tmod_t;
  // one operation entering the unit
  typedef struct packed {
    logic is_std; logic is_cvt; logic [1:0] rnd; frtm_tmod_t tmod;
    logic zero; logic sign; logic signed [13:0] exp;
    logic [51:0] frac; logic rbit; logic sticky;
    logic inv; logic dze; logic iov;
  } frtm_op_t;
  // one finished operation
  typedef struct packed {
    logic [63:0] value; frtm_exc_t exc; logic trap; logic sw;
  } frtm_res_t;
endpackage : frtm_pkg

/* verif/frtm_dispatch_model.sv */
// behavioural model of the trap dispatch logic facing the unit
`timescale 1ns/1ps
`default_nettype none
module frtm_dispatch_model (
  input wire logic clock_in, // core clock
  input wire logic nrst_in, // synchronous, active low
  input wire logic trap_req_in, // pending trap from the unit
  input wire logic slow_in, // answer late when set
  output logic trap_ack_out // one-cycle take pulse
);
  // --------------------------------------------------------------
  // trap acceptance
  // --------------------------------------------------------------
  int wait_cnt; // cycles the trap has been pending
  // a slow answer keeps the shadow open long enough to probe the barrier hold
  always @(posedge clock_in) begin
    if (!nrst_in) begin
      trap_ack_out <= 1'b0;
      wait_cnt <= 0;
    end else if (trap_req_in && !trap_ack_out) begin
      // any delay is legal, traps are imprecise
      if (wait_cnt >= (slow_in ? 20 : 1)) begin
        trap_ack_out <= 1'b1;
        wait_cnt <= 0;
      end else begin
        trap_ack_out <= 1'b0;
        wait_cnt <= wait_cnt + 1;
      end
    end else begin
      trap_ack_out <= 1'b0;
      wait_cnt <= 0;
    end
  end
endmodule : frtm_dispatch_model
`default_nettype wire

/* verif/testbench.sv */
// self-checking testbench of the fp rounding and trap mode unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import frtm_pkg::*;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  localparam logic [7:0] TRAP_TBL = 8'h6b; // expected trap per fault case
  logic clock_in = 1'b0; // 40 mhz core clock
  logic nrst_in = 1'b0;
  logic op_valid_in = 1'b0;
  frtm_op_t op_in = '0;
  logic barrier_in = 1'b0;
  logic trap_ack;
  logic slow = 1'b0; // dispatch answers late when set
  logic res_valid_out, trap_req_out, trap_sw_out, barrier_hold_out;
  frtm_res_t res_out;
  frtm_exc_t trap_exc_out;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err;
  int fails = 0, checked = 0, v;
  logic [1:0] dyn = FRTM_DYN_RST; // our copy of the dynamic field
  frtm_op_t o;

  always #12.5 clock_in = ~clock_in;

  frtm_unit dut_u (.clock_in(clock_in), .nrst_in(nrst_in), .op_valid_in(op_valid_in),
    .op_in(op_in), .barrier_in(barrier_in), .trap_ack_in(trap_ack),
    .res_valid_out(res_valid_out), .res_out(res_out), .trap_req_out(trap_req_out),
    .trap_exc_out(trap_exc_out), .trap_sw_out(trap_sw_out),
    .barrier_hold_out(barrier_hold_out), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  frtm_dispatch_model disp_u (.clock_in(clock_in), .nrst_in(nrst_in),
    .trap_req_in(trap_req_out), .slow_in(slow), .trap_ack_out(trap_ack));

  // --------------------------------------------------------------
  // checking and closing
  // --------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // expected {underflow, value}; overflow is not modelled, its value is never checked
  function automatic logic [64:0] exp_val(input frtm_op_t p);
    logic [1:0] r;
    logic up;
    logic [53:0] m;
    logic signed [13:0] e;
    r = (p.is_std && p.rnd == FRTM_RND_DYN) ? dyn : p.rnd;
    if (!p.is_std) begin
      up = (p.rnd != FRTM_RND_CHOP) && p.rbit;
    end else begin
      case (r)
        FRTM_RND_CHOP: up = 1'b0;
        FRTM_RND_MINUS: up = p.sign & (p.rbit | p.sticky);
        FRTM_RND_NORM: up = p.rbit & (p.sticky | p.frac[0]);
        default: up = !p.sign & (p.rbit | p.sticky);
      endcase
    end
    m = {2'b01, p.frac} + 54'(up);
    e = p.exp;
    if (m[53]) begin
      e = e + 14'sd1;
      m = m >> 1;
    end
    // range is judged on the rounded value
    if (e < (p.is_std ? FRTM_STD_EMIN : FRTM_LEG_EMIN)) return {1'b1, 64'h0};
    e = e + (p.is_std ? FRTM_STD_BIAS : FRTM_LEG_BIAS);
    return {1'b0, p.sign, e[10:0], m[51:0]};
  endfunction : exp_val

  // --------------------------------------------------------------
  // drivers
  // --------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clock_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock_in);
    penable <= 1'b1;
    // no fixed latency assumed, bounded wait on ready
    for (n = 0; n < 20; n++) begin
      @(posedge clock_in);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      fails++;
      wrap_up();
    end
  endtask : apb

  task automatic run_op(input frtm_op_t p, input logic vchk);
    logic [64:0] e;
    e = exp_val(p);
    @(posedge clock_in);
    op_valid_in <= 1'b1;
    op_in <= p;
    @(posedge clock_in);
    op_valid_in <= 1'b0;
    #1;
    chk(res_valid_out, 1);
    if (vchk) chk(res_out.value, e[63:0]);
    if (vchk) chk(res_out.exc.unf, e[64]);
  endtask : run_op

  // wait for the pending trap to reach a level, bounded
  task automatic wait_req(input logic lvl);
    int n;
    for (n = 0; n < 60 && trap_req_out !== lvl; n++) @(posedge clock_in);
    if (n == 60) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, trap_req_out, lvl);
      wrap_up();
    end else begin
      #1;
    end
  endtask : wait_req

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    v = $urandom(50);
    repeat (6) @(posedge clock_in);
    nrst_in <= 1'b1;
    // reset values, unmapped access
    apb(1'b0, FRTM_CTL_HI_ADDR, 32'h0);
    chk(rd, {4'h0, FRTM_DYN_RST, 26'h0});
    apb(1'b0, FRTM_TRAP_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk(err, 1);
    $display("test reset done");
    // every dynamic direction, random modifiers, exact and inexact values
    for (int d = 0; d < 4; d++) begin
      dyn = 2'(d);
      apb(1'b1, FRTM_CTL_HI_ADDR, {4'h0, dyn, 26'h0});
      apb(1'b0, FRTM_CTL_HI_ADDR, 32'h0);
      chk(rd, {4'h0, dyn, 26'h0});
      repeat (10) begin
        o = '0;
        o.is_std = 1'($urandom_range(1));
        o.rnd = 2'($urandom_range(3));
        o.sign = 1'($urandom_range(1));
        o.exp = 14'(int'($urandom_range(2000)) - 1000);
        o.frac = 52'({$urandom(), $urandom()});
        if ($urandom_range(2) != 0) o.rbit = 1'($urandom_range(1));
        if ($urandom_range(2) != 0) o.sticky = 1'($urandom_range(1));
        o.tmod.inexact = o.is_std & 1'($urandom_range(1));
        run_op(o, 1'b1);
        chk(res_out.trap, o.tmod.inexact & (o.rbit | o.sticky));
      end
    end
    $display("test rounding done");
    // just below and well below the smallest normal, all modes, both signs
    for (int c = 0; c < 32; c++) begin
      o = '0;
      o.is_std = c[0];
      o.rnd = 2'(c >> 1);
      o.sign = c[3];
      o.exp = (c[0] ? FRTM_STD_EMIN : FRTM_LEG_EMIN) - (c[4] ? 14'sd3 : 14'sd1);
      o.frac = '1;
      o.rbit = 1'b1;
      run_op(o, 1'b1);
    end
    $display("test range done");
    // invalid and divide once each; underflow, int overflow and inexact with trap mode enabled and not
    for (int k = 0; k < 8; k++) begin
      o = '0;
      o.is_std = 1'(k > 5 || $urandom_range(1));
      o.frac = 52'({$urandom(), $urandom()});
      o.tmod.enable = 1'(k % 2) | (k == 6);
      o.tmod.inexact = (k == 6);
      o.tmod.sw = (k > 5);
      case (k)
        0: o.inv = 1'b1;
        1: o.dze = 1'b1;
        2, 3: o.exp = FRTM_LEG_EMIN - 14'sd3;
        4, 5: begin
          o.is_cvt = 1'b1;
          o.iov = 1'b1;
        end
        default: o.rbit = 1'b1;
      endcase
      run_op(o, 1'(k inside {2, 3, 6, 7}));
      chk(res_out.trap, TRAP_TBL[k]);
      chk(res_out.sw, o.tmod.sw);
      if (TRAP_TBL[k]) wait_req(1'b1);
      wait_req(1'b0);
    end
    $display("test traps done");
    // standard overflow always traps and sets its sticky bit
    apb(1'b1, FRTM_CTL_HI_ADDR, {4'h0, dyn, 26'h0});
    o = '0;
    o.is_std = 1'b1;
    o.exp = FRTM_STD_EMAX + 14'sd1;
    run_op(o, 1'b0);
    chk(res_out.trap, 1);
    chk(res_out.exc, 6'h04);
    wait_req(1'b1);
    chk(trap_exc_out, 6'h04);
    apb(1'b0, FRTM_CTL_HI_ADDR, 32'h0);
    chk(rd, {4'h8, dyn, 6'h04, 20'h0});
    wait_req(1'b0);
    $display("test overflow done");
    // barrier held while a software-marked underflow trap is pending
    slow <= 1'b1;
    o = '0;
    o.is_std = 1'b1;
    o.exp = FRTM_STD_EMIN - 14'sd3;
    o.tmod.enable = 1'b1;
    o.tmod.sw = 1'b1;
    run_op(o, 1'b1);
    @(posedge clock_in);
    barrier_in <= 1'b1;
    wait_req(1'b1);
    chk(barrier_hold_out, 1);
    chk(trap_exc_out, 6'h08);
    chk(trap_sw_out, 1);
    apb(1'b0, FRTM_TRAP_ADDR, 32'h0);
    chk(rd, 32'hc8);
    wait_req(1'b0);
    chk(barrier_hold_out, 0);
    @(posedge clock_in);
    barrier_in <= 1'b0;
    $display("test barrier done");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
